// ===== src/rtc_time_pkg.sv
// Shared constants, types and digit arithmetic of the time digit register block
package rtc_time_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [5:0] SECONDS_OFFSET = 6'h00;
  localparam logic [5:0] MINUTES_OFFSET = 6'h04;
  localparam logic [5:0] HOURS_OFFSET = 6'h08;
  localparam logic [5:0] CONTROL_OFFSET = 6'h0c;

  localparam int CTRL_PAGE_BIT = 0;
  localparam int CTRL_COUNT_BIT = 1;
  localparam int CTRL_FORMAT_BIT = 2;

  // ----------------------------------------------------------------------
  // Field encodings and values after reset
  // ----------------------------------------------------------------------
  localparam logic [6:0] SEC_MAX = 7'h59;
  localparam logic [6:0] MIN_MAX = 7'h59;
  localparam logic [6:0] MIN_IGNORE = 7'h7f;
  localparam logic [5:0] HOUR24_MAX = 6'h23;
  localparam logic [4:0] HOUR12_MAX = 5'h11;
  localparam logic [5:0] HOUR_IGNORE = 6'h3f;
  localparam int HOUR_PM_BIT = 5;
  localparam logic [6:0] SEC_RESET = 7'h00;
  localparam logic [6:0] MIN_RESET = 7'h00;
  localparam logic [5:0] HOUR_RESET = 6'h00;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {SEL_SEC, SEL_MIN, SEL_HOUR, SEL_CTRL, SEL_NONE} reg_sel_e;

  // Packed decimal increment without wrap; caller handles the field limit
  function automatic logic [6:0] bcd_inc(input logic [6:0] v);
    if (v[3:0] == 4'h9)
    begin
      bcd_inc = {v[6:4] + 3'h1, 4'h0};
    end
    else
    begin
      bcd_inc = v + 7'h01;
    end
  endfunction : bcd_inc

endpackage : rtc_time_pkg

// ===== src/rtc_digit_advance.sv
// One-second advance of the seconds, minutes and hours digits
`timescale 1ns/1ps
module rtc_digit_advance (
  input wire logic tick_i,
  input wire logic format_24h_i,
  input wire logic [6:0] sec_i,
  input wire logic [6:0] min_i,
  input wire logic [5:0] hour_i,
  output logic [6:0] sec_o,
  output logic [6:0] min_o,
  output logic [5:0] hour_o
);

  always_comb
  begin
    logic [6:0] inc_hour;
    logic [6:0] inc_half;
    inc_hour = rtc_time_pkg::bcd_inc({1'b0, hour_i});
    inc_half = rtc_time_pkg::bcd_inc({2'h0, hour_i[4:0]});
    sec_o = sec_i;
    min_o = min_i;
    hour_o = hour_i;
    if (tick_i)
    begin
      if (sec_i == rtc_time_pkg::SEC_MAX)
      begin
        sec_o = 7'h00;
        if (min_i == rtc_time_pkg::MIN_MAX)
        begin
          min_o = 7'h00;
          if (format_24h_i)
          begin
            hour_o = (hour_i == rtc_time_pkg::HOUR24_MAX) ? 6'h00 : inc_hour[5:0];
          end
          else if (hour_i[4:0] == rtc_time_pkg::HOUR12_MAX)
          begin
            // Eleven rolls to zero and flips the afternoon flag
            hour_o = {~hour_i[rtc_time_pkg::HOUR_PM_BIT], 5'h00};
          end
          else
          begin
            hour_o = {hour_i[rtc_time_pkg::HOUR_PM_BIT], inc_half[4:0]};
          end
        end
        else
        begin
          min_o = rtc_time_pkg::bcd_inc(min_i);
        end
      end
      else
      begin
        sec_o = rtc_time_pkg::bcd_inc(sec_i);
      end
    end
  end

endmodule : rtc_digit_advance

// ===== src/rtc_time_digits.sv
// Seconds, minutes and hours digit registers with alarm copies of minutes and hours behind AXI4-Lite
`timescale 1ns/1ps

module rtc_time_digits (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic SECOND_TICK_I,
  input wire logic [5:0] AXI_AWADDR_I,
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  output logic [1:0] AXI_BRESP_O,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [5:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  output logic ALARM_MATCH_O
);

  function automatic rtc_time_pkg::reg_sel_e decode(input logic [5:0] addr);
    unique case (addr)
      rtc_time_pkg::SECONDS_OFFSET: decode = rtc_time_pkg::SEL_SEC;
      rtc_time_pkg::MINUTES_OFFSET: decode = rtc_time_pkg::SEL_MIN;
      rtc_time_pkg::HOURS_OFFSET: decode = rtc_time_pkg::SEL_HOUR;
      rtc_time_pkg::CONTROL_OFFSET: decode = rtc_time_pkg::SEL_CTRL;
      default: decode = rtc_time_pkg::SEL_NONE;
    endcase
  endfunction : decode

  // ----------------------------------------------------------------------
  // Write channel state
  // ----------------------------------------------------------------------
  logic aw_held_reg, aw_held_next;
  logic [5:0] aw_addr_reg, aw_addr_next;
  logic w_held_reg, w_held_next;
  logic [7:0] w_byte_reg, w_byte_next;
  logic w_lane_reg, w_lane_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic do_write;
  rtc_time_pkg::reg_sel_e wr_sel;

  assign AXI_AWREADY_O = !aw_held_reg && !bvalid_reg;
  assign AXI_WREADY_O = !w_held_reg && !bvalid_reg;
  assign AXI_BVALID_O = bvalid_reg;
  assign AXI_BRESP_O = bresp_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_sel = decode(aw_addr_reg);

  always_comb
  begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_byte_next = w_byte_reg;
    w_lane_next = w_lane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (AXI_AWVALID_I && AXI_AWREADY_O)
    begin
      aw_held_next = 1'b1;
      aw_addr_next = AXI_AWADDR_I;
    end
    if (AXI_WVALID_I && AXI_WREADY_O)
    begin
      w_held_next = 1'b1;
      w_byte_next = AXI_WDATA_I[7:0];
      w_lane_next = AXI_WSTRB_I[0];
    end
    if (do_write)
    begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wr_sel == rtc_time_pkg::SEL_NONE) ? rtc_time_pkg::RESP_SLVERR : rtc_time_pkg::RESP_OKAY;
    end
    else if (bvalid_reg && AXI_BREADY_I)
    begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 6'h00;
      w_held_reg <= 1'b0;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= rtc_time_pkg::RESP_OKAY;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_byte_reg <= w_byte_next;
      w_lane_reg <= w_lane_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // ----------------------------------------------------------------------
  // Digit registers, both pages
  // ----------------------------------------------------------------------
  logic [6:0] sec_reg, sec_next;
  logic [6:0] min_reg, min_next;
  logic [5:0] hour_reg, hour_next;
  logic [6:0] alm_min_reg, alm_min_next;
  logic [5:0] alm_hour_reg, alm_hour_next;
  logic [2:0] ctrl_reg, ctrl_next;
  logic alarm_reg, alarm_next;
  logic [6:0] adv_sec;
  logic [6:0] adv_min;
  logic [5:0] adv_hour;
  logic page_alarm;
  logic wr_ok;

  assign page_alarm = ctrl_reg[rtc_time_pkg::CTRL_PAGE_BIT];
  assign wr_ok = do_write && w_lane_reg;

  rtc_digit_advance u_advance (
    .tick_i(SECOND_TICK_I && ctrl_reg[rtc_time_pkg::CTRL_COUNT_BIT]),
    .format_24h_i(ctrl_reg[rtc_time_pkg::CTRL_FORMAT_BIT]),
    .sec_i(sec_reg),
    .min_i(min_reg),
    .hour_i(hour_reg),
    .sec_o(adv_sec),
    .min_o(adv_min),
    .hour_o(adv_hour)
  );

  always_comb
  begin
    // A software write beats the tick on the word it targets
    sec_next = adv_sec;
    min_next = adv_min;
    hour_next = adv_hour;
    alm_min_next = alm_min_reg;
    alm_hour_next = alm_hour_reg;
    ctrl_next = ctrl_reg;
    if (wr_ok)
    begin
      unique case (wr_sel)
        rtc_time_pkg::SEL_SEC:
        begin
          if (!page_alarm)
          begin
            sec_next = w_byte_reg[6:0];
          end
        end
        rtc_time_pkg::SEL_MIN:
        begin
          if (page_alarm)
          begin
            alm_min_next = w_byte_reg[6:0];
          end
          else
          begin
            min_next = w_byte_reg[6:0];
          end
        end
        rtc_time_pkg::SEL_HOUR:
        begin
          if (page_alarm)
          begin
            alm_hour_next = w_byte_reg[5:0];
          end
          else
          begin
            hour_next = w_byte_reg[5:0];
          end
        end
        rtc_time_pkg::SEL_CTRL: ctrl_next = w_byte_reg[2:0];
        rtc_time_pkg::SEL_NONE: ctrl_next = ctrl_reg;
      endcase
    end
    alarm_next = ((alm_min_reg == rtc_time_pkg::MIN_IGNORE) || (alm_min_reg == min_reg)) &&
                 ((alm_hour_reg == rtc_time_pkg::HOUR_IGNORE) || (alm_hour_reg == hour_reg));
  end

  // Digits get zero at reset only so simulation stays clean; software sets them
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      sec_reg <= rtc_time_pkg::SEC_RESET;
      min_reg <= rtc_time_pkg::MIN_RESET;
      hour_reg <= rtc_time_pkg::HOUR_RESET;
      alm_min_reg <= rtc_time_pkg::MIN_RESET;
      alm_hour_reg <= rtc_time_pkg::HOUR_RESET;
      ctrl_reg <= rtc_time_pkg::CTRL_RESET;
      alarm_reg <= 1'b0;
    end
    else
    begin
      sec_reg <= sec_next;
      min_reg <= min_next;
      hour_reg <= hour_next;
      alm_min_reg <= alm_min_next;
      alm_hour_reg <= alm_hour_next;
      ctrl_reg <= ctrl_next;
      alarm_reg <= alarm_next;
    end
  end

  assign ALARM_MATCH_O = alarm_reg;

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic ar_take;

  assign AXI_ARREADY_O = !rvalid_reg;
  assign ar_take = AXI_ARVALID_I && AXI_ARREADY_O;
  assign AXI_RVALID_O = rvalid_reg;
  assign AXI_RDATA_O = rdata_reg;
  assign AXI_RRESP_O = rresp_reg;

  always_comb
  begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_take)
    begin
      rvalid_next = 1'b1;
      rresp_next = rtc_time_pkg::RESP_OKAY;
      unique case (decode(AXI_ARADDR_I))
        rtc_time_pkg::SEL_SEC: rdata_next = {25'h0, page_alarm ? 7'h00 : sec_reg};
        rtc_time_pkg::SEL_MIN: rdata_next = {25'h0, page_alarm ? alm_min_reg : min_reg};
        rtc_time_pkg::SEL_HOUR: rdata_next = {26'h0, page_alarm ? alm_hour_reg : hour_reg};
        rtc_time_pkg::SEL_CTRL: rdata_next = {29'h0, ctrl_reg};
        rtc_time_pkg::SEL_NONE:
        begin
          rdata_next = 32'h0;
          rresp_next = rtc_time_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && AXI_RREADY_I)
    begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= rtc_time_pkg::RESP_OKAY;
    end
    else
    begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);

  logic counting;
  assign counting = SECOND_TICK_I && ctrl_reg[rtc_time_pkg::CTRL_COUNT_BIT] && !wr_ok;

  sequence s_last_second;
    counting && sec_reg == rtc_time_pkg::SEC_MAX && min_reg == rtc_time_pkg::MIN_MAX;
  endsequence

  sequence s_read_of(logic [5:0] off);
    ar_take && AXI_ARADDR_I == off;
  endsequence

  a_sec_read_zero: assert property (s_read_of(rtc_time_pkg::SECONDS_OFFSET) and !page_alarm
    |=> AXI_RVALID_O && AXI_RDATA_O[31:7] == 25'h0 && AXI_RDATA_O[6:0] == $past(sec_reg))
    else $error("seconds read wrong");

  a_alarm_sec_blank: assert property (s_read_of(rtc_time_pkg::SECONDS_OFFSET) and page_alarm
    |=> AXI_RDATA_O == 32'h0)
    else $error("alarm page seconds not zero");

  a_min_wrap_zero: assert property (s_last_second |=> min_reg == 7'h00 && sec_reg == 7'h00)
    else $error("minutes did not wrap");

  a_min_ignore_match: assert property (alm_min_reg == rtc_time_pkg::MIN_IGNORE && alm_hour_reg == hour_reg
    |=> ALARM_MATCH_O)
    else $error("ignored minutes blocked match");

  a_page_route_min: assert property (wr_ok && wr_sel == rtc_time_pkg::SEL_MIN && page_alarm && !SECOND_TICK_I
    |=> alm_min_reg == $past(w_byte_reg[6:0]) && $stable(min_reg))
    else $error("page routing wrong");

  a_hour24_wrap: assert property (s_last_second and (ctrl_reg[rtc_time_pkg::CTRL_FORMAT_BIT]
    && hour_reg == rtc_time_pkg::HOUR24_MAX) |=> hour_reg == 6'h00)
    else $error("24-hour wrap wrong");

  a_hour12_flip: assert property (s_last_second and (!ctrl_reg[rtc_time_pkg::CTRL_FORMAT_BIT]
    && hour_reg[4:0] == rtc_time_pkg::HOUR12_MAX) |=> hour_reg == {~$past(hour_reg[5]), 5'h00})
    else $error("12-hour afternoon flip wrong");

  a_hour_ignore_match: assert property (alm_hour_reg == rtc_time_pkg::HOUR_IGNORE && alm_min_reg == min_reg
    |=> ALARM_MATCH_O)
    else $error("ignored hours blocked match");

  a_hour_upper_zero: assert property (s_read_of(rtc_time_pkg::HOURS_OFFSET)
    |=> AXI_RDATA_O[31:6] == 26'h0)
    else $error("hour upper bits not zero");

endmodule : rtc_time_digits

// ===== testbench/tb.sv
// Self-checking bench for the time digit registers
`timescale 1ns/1ps
module tb;
  logic CORE_CLK_I = 1'b0, RST_I = 1'b1, SECOND_TICK_I = 1'b0;
  logic [5:0] AXI_AWADDR_I = 6'h00, AXI_ARADDR_I = 6'h00;
  logic AXI_AWVALID_I = 1'b0, AXI_WVALID_I = 1'b0, AXI_BREADY_I = 1'b0, AXI_ARVALID_I = 1'b0, AXI_RREADY_I = 1'b0;
  logic [31:0] AXI_WDATA_I = 32'h0;
  logic [3:0] AXI_WSTRB_I = 4'h0;
  logic AXI_AWREADY_O, AXI_WREADY_O, AXI_BVALID_O, AXI_ARREADY_O, AXI_RVALID_O, ALARM_MATCH_O;
  logic [1:0] AXI_BRESP_O, AXI_RRESP_O;
  logic [31:0] AXI_RDATA_O;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 32'ha307f575;
  // Reference state: time copy, alarm copy, control
  int t_sec = 0, t_min = 0, t_hour = 0, a_min = 0, a_hour = 0, ctrl = 0;
  localparam logic [5:0] o_sec = rtc_time_pkg::SECONDS_OFFSET;
  localparam logic [5:0] o_min = rtc_time_pkg::MINUTES_OFFSET;
  localparam logic [5:0] o_hr = rtc_time_pkg::HOURS_OFFSET;
  localparam logic [5:0] o_ctl = rtc_time_pkg::CONTROL_OFFSET;

  rtc_time_digits u_rtc_time_digits (
    .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .SECOND_TICK_I(SECOND_TICK_I),
    .AXI_AWADDR_I(AXI_AWADDR_I), .AXI_AWVALID_I(AXI_AWVALID_I), .AXI_AWREADY_O(AXI_AWREADY_O),
    .AXI_WDATA_I(AXI_WDATA_I), .AXI_WSTRB_I(AXI_WSTRB_I), .AXI_WVALID_I(AXI_WVALID_I),
    .AXI_WREADY_O(AXI_WREADY_O), .AXI_BRESP_O(AXI_BRESP_O), .AXI_BVALID_O(AXI_BVALID_O),
    .AXI_BREADY_I(AXI_BREADY_I), .AXI_ARADDR_I(AXI_ARADDR_I), .AXI_ARVALID_I(AXI_ARVALID_I),
    .AXI_ARREADY_O(AXI_ARREADY_O), .AXI_RDATA_O(AXI_RDATA_O), .AXI_RRESP_O(AXI_RRESP_O),
    .AXI_RVALID_O(AXI_RVALID_O), .AXI_RREADY_I(AXI_RREADY_I), .ALARM_MATCH_O(ALARM_MATCH_O)
  );

  initial
  begin
    forever #2.5 CORE_CLK_I = ~CORE_CLK_I;
  end

  // ----------------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------------
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  // Whole run needs about 750 cycles
  always @(posedge CORE_CLK_I)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      final_report();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // ----------------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------------
  function automatic int b2i(input int b);
    return (b >> 4) * 10 + (b & 15);
  endfunction : b2i

  function automatic int i2b(input int i);
    return ((i / 10) << 4) | (i % 10);
  endfunction : i2b

  function automatic int rnd(input int n);
    return ($random(seed) & 32'h7fffffff) % n;
  endfunction : rnd

  function automatic int exp_rd(input logic [5:0] a);
    case (a)
      o_sec: return ctrl[0] ? 0 : t_sec;
      o_min: return ctrl[0] ? a_min : t_min;
      o_hr: return ctrl[0] ? a_hour : t_hour;
      o_ctl: return ctrl;
      default: return 0;
    endcase
  endfunction : exp_rd

  function automatic int exp_alarm();
    return (a_min == 127 || a_min == t_min) && (a_hour == 63 || a_hour == t_hour);
  endfunction : exp_alarm

  task automatic m_tick;
    int h;
    h = b2i(t_hour & 31) + 1;
    if (ctrl[1] == 0)
      return;
    t_sec = i2b((b2i(t_sec) + 1) % 60);
    if (t_sec != 0)
      return;
    t_min = i2b((b2i(t_min) + 1) % 60);
    if (t_min != 0)
      return;
    if (ctrl[2])
      t_hour = i2b((b2i(t_hour) + 1) % 24);
    else
      t_hour = (h == 12) ? ((t_hour & 32) ^ 32) : ((t_hour & 32) | i2b(h));
  endtask : m_tick

  // ----------------------------------------------------------------------
  // Bus master; every task starts and ends just after a rising edge
  // ----------------------------------------------------------------------
  task automatic bus_wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic aw, w, b;
    AXI_AWADDR_I <= a;
    AXI_WDATA_I <= d;
    AXI_WSTRB_I <= s;
    AXI_AWVALID_I <= 1'b1;
    AXI_WVALID_I <= 1'b1;
    AXI_BREADY_I <= 1'b1;
    forever
    begin
      @(negedge CORE_CLK_I);
      aw = AXI_AWVALID_I && AXI_AWREADY_O === 1'b1;
      w = AXI_WVALID_I && AXI_WREADY_O === 1'b1;
      b = AXI_BVALID_O === 1'b1;
      r = AXI_BRESP_O;
      @(posedge CORE_CLK_I);
      if (aw)
        AXI_AWVALID_I <= 1'b0;
      if (w)
        AXI_WVALID_I <= 1'b0;
      if (b)
      begin
        AXI_BREADY_I <= 1'b0;
        // One idle edge so a following call never re-raises ready in the same step
        @(posedge CORE_CLK_I);
        break;
      end
    end
  endtask : bus_wr

  task automatic bus_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    AXI_ARADDR_I <= a;
    AXI_ARVALID_I <= 1'b1;
    AXI_RREADY_I <= 1'b1;
    forever
    begin
      @(negedge CORE_CLK_I);
      ar = AXI_ARVALID_I && AXI_ARREADY_O === 1'b1;
      v = AXI_RVALID_O === 1'b1;
      d = AXI_RDATA_O;
      r = AXI_RRESP_O;
      @(posedge CORE_CLK_I);
      if (ar)
        AXI_ARVALID_I <= 1'b0;
      if (v)
      begin
        AXI_RREADY_I <= 1'b0;
        @(posedge CORE_CLK_I);
        break;
      end
    end
  endtask : bus_rd

  function automatic logic [1:0] exp_resp(input logic [5:0] a);
    return (a inside {o_sec, o_min, o_hr, o_ctl}) ? rtc_time_pkg::RESP_OKAY : rtc_time_pkg::RESP_SLVERR;
  endfunction : exp_resp

  task automatic wr(input logic [5:0] a, input int d, input logic [3:0] s = 4'h1);
    logic [1:0] r;
    bus_wr(a, 32'(d), s, r);
    cmp(32'(r), 32'(exp_resp(a)));
    if (s[0] && a == o_sec && !ctrl[0])
      t_sec = d & 127;
    if (s[0] && a == o_min)
      if (ctrl[0])
        a_min = d & 127;
      else
        t_min = d & 127;
    if (s[0] && a == o_hr)
      if (ctrl[0])
        a_hour = d & 63;
      else
        t_hour = d & 63;
    if (s[0] && a == o_ctl)
      ctrl = d & 7;
  endtask : wr

  task automatic chk(input logic [5:0] a);
    logic [31:0] d;
    logic [1:0] r;
    bus_rd(a, d, r);
    cmp(d, 32'(exp_rd(a)));
    cmp(32'(r), 32'(exp_resp(a)));
    @(negedge CORE_CLK_I);
    cmp(32'(ALARM_MATCH_O), 32'(exp_alarm()));
    @(posedge CORE_CLK_I);
  endtask : chk

  task automatic tick;
    SECOND_TICK_I <= 1'b1;
    @(posedge CORE_CLK_I);
    SECOND_TICK_I <= 1'b0;
    @(posedge CORE_CLK_I);
    m_tick();
  endtask : tick

  task automatic chk_time;
    chk(o_sec);
    chk(o_sec);
    chk(o_min);
    chk(o_hr);
  endtask : chk_time

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  int starts[5] = '{32'h63, 32'h09, 32'h11, 32'h31, 32'h29};
  int h;

  initial
  begin
    repeat (3) @(posedge CORE_CLK_I);
    RST_I <= 1'b0;
    @(posedge CORE_CLK_I);
    for (int i = 0; i < 4; i++)
      chk(6'(4 * i));
    wr(6'h10, 'h55);
    chk(6'h10);
    wr(6'h3c, 'h12);
    chk(6'h3c);
    wr(o_sec, 'h21, 4'h0);
    chk(o_sec);
    wr(o_sec, 'hd9);
    chk(o_sec);
    wr(o_min, 'hd9);
    chk(o_min);
    wr(o_ctl, 4);
    wr(o_hr, 'he3);
    chk(o_hr);
    // Rollover corners; bit 6 of a start picks 24-hour format
    for (int i = 0; i < 5; i++)
    begin
      wr(o_ctl, starts[i][6] ? 6 : 2);
      wr(o_sec, 'h58);
      wr(o_min, 'h59);
      wr(o_hr, starts[i] & 63);
      tick();
      tick();
      chk_time();
      tick();
      chk_time();
    end
    // Random valid encodings only, since others are undefined
    for (int i = 0; i < 8; i++)
    begin
      wr(o_ctl, 2 | (rnd(2) << 2));
      wr(o_sec, i2b(rnd(60)));
      wr(o_min, i2b(rnd(60)));
      h = ctrl[2] ? i2b(rnd(24)) : ((rnd(2) << 5) | i2b(rnd(12)));
      wr(o_hr, h);
      repeat (1 + rnd(4)) tick();
      chk_time();
    end
    // Alarm page
    wr(o_ctl, 5);
    chk(o_ctl);
    wr(o_sec, 'h30);
    chk(o_sec);
    wr(o_min, t_min);
    wr(o_hr, t_hour);
    chk(o_min);
    chk(o_hr);
    wr(o_min, i2b((b2i(t_min) + 1) % 60));
    chk(o_min);
    wr(o_min, 'h7f);
    chk(o_min);
    wr(o_hr, i2b((b2i(t_hour) + 1) % 24));
    chk(o_hr);
    wr(o_hr, 'h3f);
    chk(o_hr);
    // Hours ignored with minutes matching again
    wr(o_min, t_min);
    chk(o_min);
    wr(o_ctl, 4);
    chk_time();
    final_report();
  end
endmodule : tb
